// ### block_move_pkg.sv
// constants, encodings and states for the block move sequencer
// assumes a 16-bit cpu datapath with eight auxiliary registers
package block_move_pkg;
  localparam int WORD_W = 16;
  localparam int AUX_COUNT = 8;
  localparam int AUX_SEL_W = 3;
  localparam int PAGE_W = 9;
  localparam int DMA_W = 7;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_LEVEL_W = 5;
  localparam int CLK_PERIOD_NS = 25;
  // upper opcode byte of each form
  localparam logic [7:0] OP_DATA_SRC_LONG = 8'ha8;
  localparam logic [7:0] OP_DATA_DST_LONG = 8'ha9;
  localparam logic [7:0] OP_PROG_SRC_LONG = 8'ha5;
  // opcode field positions
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 8;
  localparam int IND_BIT = 7;
  localparam int MODE_HI = 6;
  localparam int MODE_LO = 4;
  localparam int NEXT_BIT = 3;
  localparam int NAR_HI = 2;
  localparam int NAR_LO = 0;
  // indirect update options
  localparam logic [2:0] IND_NONE = 3'h0;
  localparam logic [2:0] IND_DEC = 3'h1;
  localparam logic [2:0] IND_INC = 3'h2;
  localparam logic [2:0] IND_RSVD = 3'h3;
  localparam logic [2:0] IND_BR_SUB = 3'h4;
  localparam logic [2:0] IND_SUB_IDX = 3'h5;
  localparam logic [2:0] IND_ADD_IDX = 3'h6;
  localparam logic [2:0] IND_BR_ADD = 3'h7;
  localparam logic [15:0] RETURN_STEP = 16'h0002;
  localparam logic [15:0] POINTER_STEP = 16'h0001;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_DRAIN = 4'b0100,
    ST_RESTORE = 4'b1000
  } seq_state_e;
endpackage

// ### move_fifo.sv
// small flip-flop fifo carrying moved words toward the write port
// assumes one clock, synchronous active-low reset
`timescale 1ns/100ps
module move_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int LEVEL_W = 5
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [LEVEL_W-1:0] level_o
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [LEVEL_W-1:0] level_reg;
  logic push;
  logic pop;

  assign in_ready_o = (level_reg != LEVEL_W'(DEPTH));
  assign out_valid_o = (level_reg != '0);
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign level_o = level_reg;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        level_reg <= level_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        level_reg <= level_reg - 1'b1;
      end
    end
  end
endmodule

// ### block_move_sequencer.sv
// sequencer for the data-to-data and program-to-data block moves
// assumes the decoder hands over both instruction words in one start pulse,
// memories answer reads in order, and the cpu holds its datapath while busy
// Notes on behaviour
// RULE1: data move copies source word unchanged
// RULE2: long immediate on one side, other direct/indirect
// RULE3: software never moves memory-mapped registers this way
// RULE4: repeated move transfers count plus one
// RULE5: save return address, restore at end
// RULE6: long immediate pointer advances by one
// RULE7: indirect operand updates aux register each transfer
// RULE8: direct operand address stays constant
// RULE9: source and destination placed independently
// RULE10: interrupts held off during repeated data move
// RULE11: repeated transfers single cycle without waits
// RULE12: single internal move takes three cycles
// RULE13: external destination adds its wait states
// RULE14: repeated internal move near n plus two
// RULE15: external repeated move pays waits per word
// RULE16: program move reads program memory at pointer
// RULE17: program move destination direct or indirect
// RULE18: decode address, direct field, aux selector
// RULE19: repeated program move holds interrupts too
// RULE20: program source wait states stretch the read
// RULE21: seven indirect update options
// RULE22: two words, status bits untouched
`timescale 1ns/100ps
module block_move_sequencer
  import block_move_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic [WORD_W-1:0] opcode_i,
  input wire logic [WORD_W-1:0] long_word_i,
  input wire logic [WORD_W-1:0] pc_i,
  input wire logic repeat_active_i,
  input wire logic [WORD_W-1:0] repeat_count_i,
  input wire logic [PAGE_W-1:0] data_page_i,
  input wire logic aux_load_i,
  input wire logic [AUX_SEL_W-1:0] aux_load_sel_i,
  input wire logic [WORD_W-1:0] aux_load_value_i,
  input wire logic aux_pointer_load_i,
  input wire logic [AUX_SEL_W-1:0] aux_pointer_value_i,
  input wire logic rd_ready_i,
  input wire logic rd_valid_i,
  input wire logic [WORD_W-1:0] rd_data_i,
  input wire logic wr_ready_i,
  output logic busy_o,
  output logic illegal_o,
  output logic done_o,
  output logic rd_req_o,
  output logic rd_program_o,
  output logic [WORD_W-1:0] rd_addr_o,
  output logic wr_req_o,
  output logic [WORD_W-1:0] wr_addr_o,
  output logic [WORD_W-1:0] wr_data_o,
  output logic [WORD_W-1:0] pc_o,
  output logic pc_load_o,
  output logic [WORD_W-1:0] repeat_count_o,
  output logic int_inhibit_o,
  output logic [AUX_SEL_W-1:0] aux_pointer_o,
  output logic [WORD_W-1:0] aux_value_o
);
  localparam int LVL_W = FIFO_LEVEL_W;

  seq_state_e state_reg;
  logic [WORD_W-1:0] aux_reg [AUX_COUNT];
  logic [AUX_SEL_W-1:0] aux_ptr_reg;
  logic [WORD_W-1:0] micro_stack_reg;
  logic [WORD_W-1:0] pc_reg;
  logic [WORD_W-1:0] direct_addr_reg;
  logic [WORD_W-1:0] count_reg;
  logic first_reg;
  logic src_long_reg;
  logic indirect_reg;
  logic program_reg;
  logic repeat_reg;
  logic [2:0] mode_reg;
  logic next_reg;
  logic [AUX_SEL_W-1:0] nar_reg;
  logic [LVL_W-1:0] inflight_reg;
  logic rd_req_reg;
  logic [WORD_W-1:0] rd_addr_reg;
  logic wr_req_reg;
  logic [WORD_W-1:0] wr_addr_reg;
  logic [WORD_W-1:0] wr_data_reg;
  logic pc_load_reg;
  logic done_reg;
  logic illegal_reg;
  logic busy_reg;
  logic inhibit_reg;
  logic [WORD_W-1:0] aux_value_reg;
  logic [7:0] opc;
  logic legal;
  logic take;
  logic more;
  logic issue;
  logic accept;
  logic [WORD_W-1:0] dst_addr;
  logic aux_step;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [2*WORD_W-1:0] fifo_out_data;
  logic [LVL_W-1:0] fifo_level;

  function automatic logic [WORD_W-1:0] bit_rev(input logic [WORD_W-1:0] v);
    logic [WORD_W-1:0] r;
    r = '0;
    for (int i = 0; i < WORD_W; i++)
    begin
      r[i] = v[WORD_W-1-i];
    end
    return r;
  endfunction

  // one of the seven indirect update options applied to an aux register
  function automatic logic [WORD_W-1:0] aux_modify(input logic [WORD_W-1:0] a,
                                                   input logic [WORD_W-1:0] idx,
                                                   input logic [2:0] mode);
    logic [WORD_W-1:0] r;
    r = a;
    case (mode)
      IND_DEC: r = a - 1'b1;
      IND_INC: r = a + 1'b1;
      IND_ADD_IDX: r = a + idx;
      IND_SUB_IDX: r = a - idx;
      IND_BR_ADD: r = bit_rev(bit_rev(a) + bit_rev(idx));
      IND_BR_SUB: r = bit_rev(bit_rev(a) - bit_rev(idx));
      default: r = a;
    endcase
    return r;
  endfunction

  assign opc = opcode_i[OPC_HI:OPC_LO];
  assign legal = (opc == OP_DATA_SRC_LONG) || (opc == OP_DATA_DST_LONG) || // [RULE2]
                 (opc == OP_PROG_SRC_LONG);
  assign take = start_i && (state_reg == ST_IDLE) && legal;
  // the fifo credit keeps every returning word a place, so reads never overrun
  assign more = (state_reg == ST_RUN) && (first_reg || count_reg != COUNT_RESET); // [RULE4]
  assign issue = more && (!rd_req_reg || rd_ready_i) &&
                 (LVL_W'(inflight_reg + fifo_level) < LVL_W'(DEPTH)); // [RULE11] [RULE12] [RULE14]
  assign accept = rd_req_reg && rd_ready_i;
  assign aux_step = indirect_reg && ((src_long_reg && rd_valid_i) || // [RULE7]
                                     (!src_long_reg && issue));
  assign dst_addr = src_long_reg ? (indirect_reg ? aux_reg[aux_ptr_reg] : direct_addr_reg)
                                 : pc_reg; // [RULE8]
  assign fifo_out_ready = !wr_req_reg || wr_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      case (state_reg)
        ST_IDLE: if (take) state_reg <= ST_RUN;
        ST_RUN: if (!more) state_reg <= ST_DRAIN;
        ST_DRAIN:
          if (inflight_reg == '0 && !fifo_out_valid && !wr_req_reg && !rd_req_reg)
            state_reg <= ST_RESTORE;
        ST_RESTORE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // decode and latch the opcode word and return address at start
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      src_long_reg <= 1'b1;
      indirect_reg <= 1'b0;
      program_reg <= 1'b0;
      repeat_reg <= 1'b0;
      mode_reg <= IND_NONE;
      next_reg <= 1'b0;
      nar_reg <= '0;
      direct_addr_reg <= ADDR_RESET;
      micro_stack_reg <= ADDR_RESET;
    end
    else if (take)
    begin
      src_long_reg <= (opc != OP_DATA_DST_LONG); // [RULE16] [RULE17]
      program_reg <= (opc == OP_PROG_SRC_LONG);
      indirect_reg <= opcode_i[IND_BIT];
      mode_reg <= opcode_i[MODE_HI:MODE_LO]; // [RULE21]
      next_reg <= opcode_i[NEXT_BIT];
      nar_reg <= opcode_i[NAR_HI:NAR_LO]; // [RULE18]
      direct_addr_reg <= {data_page_i, opcode_i[DMA_W-1:0]}; // [RULE18]
      repeat_reg <= repeat_active_i;
      micro_stack_reg <= pc_i + RETURN_STEP; // [RULE5] [RULE22]
    end
  end

  // long immediate pointer: loaded at start, stepped per transfer, restored at end
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      pc_reg <= ADDR_RESET;
      pc_load_reg <= 1'b0;
    end
    else
    begin
      pc_load_reg <= (state_reg == ST_RESTORE);
      if (take)
        pc_reg <= long_word_i; // [RULE5]
      else if (state_reg == ST_RESTORE)
        pc_reg <= micro_stack_reg; // [RULE5]
      else if ((src_long_reg && issue) || (!src_long_reg && rd_valid_i))
        pc_reg <= pc_reg + POINTER_STEP; // [RULE6]
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      count_reg <= COUNT_RESET;
      first_reg <= 1'b0;
    end
    else if (take)
    begin
      count_reg <= repeat_active_i ? repeat_count_i : COUNT_RESET; // [RULE4]
      first_reg <= 1'b1;
    end
    else if (issue)
    begin
      first_reg <= 1'b0;
      if (!first_reg)
        count_reg <= count_reg - 1'b1; // [RULE4]
    end
  end

  // read side: one request may be outstanding on the port, more in flight
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rd_req_reg <= 1'b0;
      rd_addr_reg <= ADDR_RESET;
      inflight_reg <= '0;
    end
    else
    begin
      if (issue)
      begin
        rd_req_reg <= 1'b1;
        rd_addr_reg <= src_long_reg ? pc_reg :
                       (indirect_reg ? aux_reg[aux_ptr_reg] : direct_addr_reg); // [RULE8]
      end
      else if (accept)
        rd_req_reg <= 1'b0;
      if (issue && !rd_valid_i)
        inflight_reg <= inflight_reg + 1'b1;
      else if (rd_valid_i && !issue)
        inflight_reg <= inflight_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      aux_ptr_reg <= '0;
      for (int i = 0; i < AUX_COUNT; i++)
        aux_reg[i] <= ADDR_RESET;
    end
    else if (aux_step)
    begin
      aux_reg[aux_ptr_reg] <= aux_modify(aux_reg[aux_ptr_reg], aux_reg[0], mode_reg); // [RULE7]
      if (next_reg)
        aux_ptr_reg <= nar_reg; // [RULE7]
    end
    else
    begin
      // cpu loads are only honoured in cycles without an aux update
      if (aux_load_i)
        aux_reg[aux_load_sel_i] <= aux_load_value_i;
      if (aux_pointer_load_i)
        aux_ptr_reg <= aux_pointer_value_i;
    end
  end

  // returning words carry their destination address with them
  move_fifo #(
    .WIDTH(2 * WORD_W),
    .DEPTH(DEPTH),
    .LEVEL_W(LVL_W)
  ) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(rd_valid_i),
    .in_ready_o(fifo_in_ready),
    .in_data_i({dst_addr, rd_data_i}), // [RULE1] [RULE9]
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data),
    .level_o(fifo_level)
  );

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      wr_req_reg <= 1'b0;
      wr_addr_reg <= ADDR_RESET;
      wr_data_reg <= ADDR_RESET;
    end
    else if (fifo_out_ready)
    begin
      wr_req_reg <= fifo_out_valid; // [RULE13] [RULE15]
      if (fifo_out_valid)
      begin
        wr_addr_reg <= fifo_out_data[2*WORD_W-1:WORD_W];
        wr_data_reg <= fifo_out_data[WORD_W-1:0]; // [RULE1]
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      busy_reg <= 1'b0;
      inhibit_reg <= 1'b0;
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
      aux_value_reg <= ADDR_RESET;
    end
    else
    begin
      busy_reg <= take || (busy_reg && state_reg != ST_RESTORE);
      inhibit_reg <= (take && repeat_active_i) ||
                     (inhibit_reg && state_reg != ST_RESTORE); // [RULE10] [RULE19]
      done_reg <= (state_reg == ST_RESTORE);
      illegal_reg <= start_i && (state_reg == ST_IDLE) && !legal;
      // output stays a flop; it trails an aux update by one cycle
      aux_value_reg <= aux_reg[aux_ptr_reg];
    end
  end

  assign busy_o = busy_reg;
  assign illegal_o = illegal_reg;
  assign done_o = done_reg;
  assign rd_req_o = rd_req_reg;
  assign rd_program_o = program_reg; // [RULE16] [RULE20]
  assign rd_addr_o = rd_addr_reg;
  assign wr_req_o = wr_req_reg;
  assign wr_addr_o = wr_addr_reg;
  assign wr_data_o = wr_data_reg;
  assign pc_o = pc_reg;
  assign pc_load_o = pc_load_reg;
  assign repeat_count_o = count_reg;
  assign int_inhibit_o = inhibit_reg;
  assign aux_pointer_o = aux_ptr_reg;
  assign aux_value_o = aux_value_reg;

  sequence seq_start;
    take && repeat_active_i;
  endsequence
  sequence seq_held;
    int_inhibit_o [*2];
  endsequence

  a_stack_save: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE5]
    take |=> micro_stack_reg == $past(pc_i) + RETURN_STEP && pc_o == $past(long_word_i))
    else $error("return address or pointer not loaded at start");
  a_pc_restore: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE5]
    (state_reg == ST_RESTORE) |=> pc_load_o && done_o && pc_o == $past(micro_stack_reg))
    else $error("pointer not restored at end");
  a_pointer_step: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE6]
    (issue && src_long_reg) |=> rd_addr_o == $past(pc_reg) && pc_o == $past(pc_reg) + 1'b1)
    else $error("long immediate pointer did not step");
  a_direct_fixed: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE8]
    (rd_req_o && src_long_reg == 1'b0 && !indirect_reg) |-> rd_addr_o == direct_addr_reg)
    else $error("direct address moved");
  a_count_step: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE4]
    (issue && !first_reg) |=> repeat_count_o == $past(repeat_count_o) - 1'b1)
    else $error("repeat counter not decremented");
  a_count_stop: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE4]
    (busy_o && !first_reg && repeat_count_o == COUNT_RESET) |-> !issue)
    else $error("read issued past the last word");
  a_int_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE10]
    seq_start |=> seq_held)
    else $error("interrupts not held during repeated move");
  a_first_read: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE12]
    take |=> ##1 rd_req_o)
    else $error("first read not requested two cycles after start");
  a_aux_update: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE7]
    (aux_step && mode_reg == IND_INC && !next_reg) |=>
      aux_reg[aux_ptr_reg] == $past(aux_reg[aux_ptr_reg]) + 1'b1)
    else $error("aux register not incremented");
  a_fifo_room: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE11]
    rd_valid_i |-> fifo_in_ready)
    else $error("returning word found no room");
endmodule

// ### mem_partner.sv
// memory model on the sequencer's read and write ports
// assumes in-order reads; slow_i adds random stalls and latency
`timescale 1ns/100ps
module mem_partner (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic rd_req_i,
  input wire logic rd_program_i,
  input wire logic [15:0] rd_addr_i,
  output logic rd_ready_o,
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  output logic wr_ready_o
);
  logic [15:0] word_q[$];
  int due_q[$];
  int cyc = 0;
  initial
  begin
    rd_ready_o = 1'b0;
    rd_valid_o = 1'b0;
    rd_data_o = 16'h0000;
    wr_ready_o = 1'b0;
  end
  // content depends on space, so a read from the wrong space shows
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (rd_req_i && rd_ready_o)
    begin
      word_q.push_back({rd_addr_i[7:0], rd_addr_i[15:8]} ^ (rd_program_i ? 16'hc3c3 : 16'h3c3c));
      due_q.push_back(cyc + (slow_i ? $urandom_range(3, 1) : 1));
    end
  end
  // read and write sides stall independently
  always @(negedge clk_i)
  begin
    rd_ready_o <= slow_i ? ($urandom_range(3) != 0) : 1'b1;
    wr_ready_o <= slow_i ? ($urandom_range(3) == 0) : 1'b1;
    if (due_q.size() != 0 && due_q[0] <= cyc)
    begin
      rd_valid_o <= 1'b1;
      rd_data_o <= word_q.pop_front();
      void'(due_q.pop_front());
    end
    else
    begin
      // released data lines invert each idle cycle, so every second one holds a stale copy
      rd_valid_o <= 1'b0;
      rd_data_o <= ~rd_data_o;
    end
  end
endmodule

// ### tb.sv
// self-checking bench: random block moves against the memory model
// assumes the design package and the sequencer's handover timing
`timescale 1ns/100ps
module tb;
  import block_move_pkg::*;
  typedef struct {logic [15:0] a; logic [15:0] d; logic ih; logic f;} wr_s;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic start_i = 1'b0;
  logic [15:0] opcode_i = 16'h0000;
  logic [15:0] long_word_i = 16'h0000;
  logic [15:0] pc_i = 16'h0000;
  logic repeat_active_i = 1'b0;
  logic [15:0] repeat_count_i = 16'h0000;
  logic [8:0] data_page_i = 9'h000;
  logic aux_load_i = 1'b0;
  logic [2:0] aux_load_sel_i = 3'h0;
  logic [15:0] aux_load_value_i = 16'h0000;
  logic aux_pointer_load_i = 1'b0;
  logic [2:0] aux_pointer_value_i = 3'h0;
  logic slow = 1'b0;
  logic rd_ready_i, rd_valid_i, wr_ready_i;
  logic [15:0] rd_data_i;
  logic busy_o, illegal_o, done_o, rd_req_o, rd_program_o, wr_req_o, pc_load_o, int_inhibit_o;
  logic [15:0] rd_addr_o, wr_addr_o, wr_data_o, pc_o, repeat_count_o, aux_value_o;
  logic [2:0] aux_pointer_o;
  wr_s wq[$];
  wr_s w;
  logic [15:0] dq[$];
  logic [15:0] aux[8];
  logic [2:0] aux_pointer_select = 3'h0;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int lastw = 0;
  block_move_sequencer u_block_move_sequencer (.clk_i, .rstn_i, .start_i, .opcode_i,
    .long_word_i, .pc_i, .repeat_active_i, .repeat_count_i, .data_page_i, .aux_load_i,
    .aux_load_sel_i, .aux_load_value_i, .aux_pointer_load_i, .aux_pointer_value_i,
    .rd_ready_i, .rd_valid_i, .rd_data_i, .wr_ready_i, .busy_o, .illegal_o, .done_o,
    .rd_req_o, .rd_program_o, .rd_addr_o, .wr_req_o, .wr_addr_o, .wr_data_o, .pc_o,
    .pc_load_o, .repeat_count_o, .int_inhibit_o, .aux_pointer_o, .aux_value_o);
  mem_partner u_mem_partner (.clk_i, .slow_i(slow), .rd_req_i(rd_req_o),
    .rd_program_i(rd_program_o), .rd_addr_i(rd_addr_o), .rd_ready_o(rd_ready_i),
    .rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i), .wr_ready_o(wr_ready_i));
  always #(CLK_PERIOD_NS / 2.0) clk_i = ~clk_i;
  task automatic conclude();
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_flag(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  function automatic logic [15:0] rev(input logic [15:0] v);
    for (int i = 0; i < 16; i++)
      rev[i] = v[15 - i];
  endfunction
  function automatic logic [15:0] upd(input logic [15:0] a, input logic [2:0] m);
    case (m)
      IND_DEC: upd = a - 16'h0001;
      IND_INC: upd = a + 16'h0001;
      IND_SUB_IDX: upd = a - aux[0];
      IND_ADD_IDX: upd = a + aux[0];
      IND_BR_ADD: upd = rev(rev(a) + rev(aux[0]));
      IND_BR_SUB: upd = rev(rev(a) - rev(aux[0]));
      default: upd = a;
    endcase
  endfunction
  task automatic load_aux();
    for (int r = 0; r < 8; r++)
    begin
      @(negedge clk_i);
      aux[r] = {1'b1, 15'($urandom)};
      aux_load_i = 1'b1;
      aux_load_sel_i = 3'(r);
      aux_load_value_i = aux[r];
    end
    @(negedge clk_i);
    aux_load_i = 1'b0;
    aux_pointer_select = 3'($urandom);
    aux_pointer_load_i = 1'b1;
    aux_pointer_value_i = aux_pointer_select;
    @(negedge clk_i);
    aux_pointer_load_i = 1'b0;
  endtask
  task automatic run_move(input logic [7:0] op, input logic [7:0] lo, input logic rep,
                          input logic [15:0] cnt);
    logic [15:0] lk;
    logic [15:0] dir;
    logic [15:0] ra;
    logic [15:0] wa;
    int n;
    int t;
    // high operand addresses keep clear of mapped registers
    lk = {1'b1, 15'($urandom)};
    data_page_i = 9'($urandom_range(511, 4));
    dir = {data_page_i, lo[6:0]};
    n = rep ? cnt + 1 : 1;
    for (int i = 0; i < n; i++)
    begin
      ra = (op == OP_DATA_DST_LONG) ? (lo[7] ? aux[aux_pointer_select] : dir) : lk + 16'(i);
      wa = (op == OP_DATA_DST_LONG) ? lk + 16'(i) : (lo[7] ? aux[aux_pointer_select] : dir);
      wq.push_back('{wa, {ra[7:0], ra[15:8]} ^ (op == OP_PROG_SRC_LONG ? 16'hc3c3 : 16'h3c3c),
                     rep, i == 0});
      if (lo[7])
      begin
        aux[aux_pointer_select] = upd(aux[aux_pointer_select], lo[6:4]);
        if (lo[3])
          aux_pointer_select = lo[2:0];
      end
    end
    pc_i = 16'($urandom);
    dq.push_back(pc_i + RETURN_STEP);
    opcode_i = {op, lo};
    long_word_i = lk;
    repeat_active_i = rep;
    repeat_count_i = cnt;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    long_word_i = ~lk;
    pc_i = ~pc_i;
    repeat_count_i = ~cnt;
    data_page_i = ~data_page_i;
    repeat (2) @(negedge clk_i);
    // a second issue while busy must leave no trace
    opcode_i = {OP_DATA_SRC_LONG, 8'h00};
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    t = 0;
    while (done_o !== 1'b1 && t < 3000)
    begin
      @(negedge clk_i);
      t++;
    end
    cmp_flag("move finished", 1'b1, done_o);
    // zero-wait memory: one extra cycle per extra word, fixed pipeline overhead
    if (!slow)
      cmp_word("move length", 16'(n + 3), 16'(t));
    cmp_word("aux value", aux[aux_pointer_select], aux_value_o);
    cmp_word("aux pointer", {13'h0000, aux_pointer_select}, {13'h0000, aux_pointer_o});
    if (rep)
      cmp_word("repeat count", 16'h0000, repeat_count_o);
    cmp_word("pending writes", 16'h0000, 16'(wq.size()));
  endtask
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      conclude();
    end
    if (wr_req_o === 1'b1 && wr_ready_i)
    begin
      if (wq.size() == 0)
        cmp_flag("spare write", 1'b0, 1'b1);
      else
      begin
        w = wq.pop_front();
        cmp_word("write address", w.a, wr_addr_o);
        cmp_word("write data", w.d, wr_data_o);
        cmp_flag("interrupt hold", w.ih, int_inhibit_o);
        if (!slow && w.ih && !w.f)
          cmp_word("write spacing", 16'h0001, 16'(cyc - lastw));
        lastw = cyc;
      end
    end
    if (done_o === 1'b1)
    begin
      cmp_word("return pointer", dq.pop_front(), pc_o);
      cmp_flag("pointer load", 1'b1, pc_load_o);
    end
  end
  initial
  begin
    logic [7:0] ops[3];
    int idx;
    ops = '{OP_DATA_SRC_LONG, OP_DATA_DST_LONG, OP_PROG_SRC_LONG};
    void'($urandom(32'h676c));
    repeat (4) @(negedge clk_i);
    rstn_i = 1'b1;
    cmp_flag("reset inhibit", 1'b0, int_inhibit_o);
    cmp_word("reset pointer", 16'h0000, pc_o);
    for (int k = 0; k < 54; k++)
    begin
      idx = k / 3;
      slow = idx[0];
      if (idx < 16)
        load_aux();
      run_move(ops[k % 3], idx < 16 ? {1'b1, 3'(idx), k[0], 3'($urandom)} : {1'b0, 7'($urandom)},
               k % 4 != 1, 16'(k == 52 ? 40 : $urandom_range(12)));
    end
    opcode_i = 16'h0012;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    cmp_flag("illegal flag", 1'b1, illegal_o);
    cmp_flag("busy on illegal", 1'b0, busy_o);
    repeat (20) @(negedge clk_i);
    conclude();
  end
endmodule
